// *** verilog/tgd_sequencer.sv ***
`timescale 1ns/1ns
// Functional notes
// - the two slices start their cycles half a period apart.
// - fixed period counter; one on/off cycle per slice per period.
// - each slice's comparator output commands its high-side pulse width.
// - high-side and low-side of one slice are never on together.
// - after high-side off, wait switch node low, then 50 ns, then low-side.
// - after low-side off, wait low-side gate below threshold, then high-side.
// - high-side on time capped at the lesser of 90 percent of the period and the period less minimum low-side and dead delay.
// - low-side stays on at least 330 ns every period unless enable low or light load mode turns the slice off mid-pulse.
// - current sense window open only while low-side is on.
// - overvoltage latches low-side on, high-side off, until reset.
// - enable low stops switching and pulls power good low.
// - light load mode keeps the first slice fully off, except that overvoltage still latches its low-side on.
module tgd_sequencer
  import tgd_pkg::*;
#(
  parameter int PERIOD_CYC = tgd_pkg::PERIOD_CYC_DEF
)
(
  input  wire logic               ref_clk,
  input  wire logic               rst,
  input  wire tgd_pkg::tgd_sense_s sense,
  input  wire tgd_pkg::tgd_ctl_s   ctl,
  output      tgd_pkg::tgd_drive_s drive,
  output      logic               power_good_allow,
  output      logic               overvoltage_latched
);
  import tgd_pkg::*;

  localparam int HALF_CYC    = PERIOD_CYC / 2;
  localparam int LIM_DUTY    = (PERIOD_CYC * MAX_DUTY_PCT) / PCT_FULL;
  localparam int LIM_LS      = PERIOD_CYC - MIN_LS_CYC - DEAD_DELAY_CYC;
  // max-duty cap is counted from local time zero, not from the actual rise
  localparam int HS_LIM      = (LIM_DUTY < LIM_LS) ? LIM_DUTY : LIM_LS;

  generate
    if (PERIOD_CYC % 2 != 0)
    begin : g_bad_odd
      $error("tgd_sequencer: period must be even for the half-period offset");
    end
    if (PERIOD_CYC >= (1 << CNT_W))
    begin : g_bad_wide
      $error("tgd_sequencer: period does not fit the period counter");
    end
    if (HS_LIM < 1)
    begin : g_bad_lim
      $error("tgd_sequencer: period too short for the minimum low-side time");
    end
    if (MIN_LS_CYC >= (1 << TMR_W) - 1)
    begin : g_bad_tmr
      $error("tgd_sequencer: minimum low-side time overflows the slice timer");
    end
    if (DEAD_DELAY_CYC < 1)
    begin : g_bad_dead
      $error("tgd_sequencer: dead delay must be at least one clock");
    end
  endgenerate

  typedef struct packed {
    tgd_sense_s               sense1;
    tgd_sense_s               sense2;
    tgd_ctl_s                 ctl1;
    tgd_ctl_s                 ctl2;
    logic                     fault;
    logic [CNT_W-1:0]         cnt;
    tgd_slice_s [SLICES-1:0]  sl;
    tgd_drive_s               drv;
    logic                     pg;
  } tgd_state_s;

  tgd_state_s state_r;
  tgd_state_s state_nxt;

  // slice position in its own period; slice b runs half a period behind
  function automatic logic [CNT_W-1:0] local_time(input logic [CNT_W-1:0] c, input int idx);
    logic [CNT_W-1:0] half;
    half = CNT_W'(HALF_CYC);
    if (idx == SLICE_A)
      local_time = c;
    else if (c >= half)
      local_time = c - half;
    else
      local_time = c + half;
  endfunction : local_time

  // saturates so a long low-side stretch never wraps below the minimum
  function automatic logic [TMR_W-1:0] tmr_step(input logic [TMR_W-1:0] v);
    if (v == '1)
      tmr_step = v;
    else
      tmr_step = v + TMR_W'(1);
  endfunction : tmr_step

  // fault path: park in the dead delay so low-side still waits its gap
  function automatic tgd_slice_s park_slice();
    tgd_slice_s s;
    s.st  = TGD_LS_DELAY;
    s.tmr = '0;
    return s;
  endfunction : park_slice

  always_comb
  begin
    logic [CNT_W-1:0] t;
    logic             start;
    logic             run;
    logic             cmd;
    state_nxt        = state_r;
    t                = '0;
    start            = 1'b0;
    run              = 1'b0;
    cmd              = 1'b0;
    state_nxt.sense1 = sense;
    state_nxt.sense2 = state_r.sense1;
    state_nxt.ctl1   = ctl;
    state_nxt.ctl2   = state_r.ctl1;
    state_nxt.fault  = state_r.fault | state_r.ctl2.overvoltage;

    if (state_r.cnt == CNT_W'(PERIOD_CYC - 1))
      state_nxt.cnt = '0;
    else
      state_nxt.cnt = state_r.cnt + CNT_W'(1);

    for (int i = 0; i < SLICES; i++)
    begin
      t     = local_time(state_r.cnt, i);
      start = (t == '0);
      run   = state_r.ctl2.enable && !state_r.fault
              && !(i == SLICE_A && state_r.ctl2.light_load_efficiency_mode);
      cmd   = state_r.sense2.pwm_cmd[i];

      case (state_r.sl[i].st)
        TGD_OFF:
        begin
          // a slice only starts at its own local time zero
          if (state_r.fault)
          begin
            state_nxt.sl[i] = park_slice();
          end
          else if (run && start && cmd)
            state_nxt.sl[i].st = TGD_WAIT_LOW_SIDE_GATE_DRIVE;
        end

        TGD_WAIT_LOW_SIDE_GATE_DRIVE:
        begin
          if (state_r.fault)
          begin
            state_nxt.sl[i] = park_slice();
          end
          else if (!run)
            state_nxt.sl[i].st = TGD_OFF;
          else if (state_r.sense2.low_side_gate_low[i])
            state_nxt.sl[i].st = TGD_HS_ON;
        end

        TGD_HS_ON:
        begin
          if (!run || !cmd || t >= CNT_W'(HS_LIM - 1))
            state_nxt.sl[i].st = TGD_WAIT_SW;
        end

        TGD_WAIT_SW:
        begin
          // low-side waits for the switch node, never a fixed guess
          if (state_r.sense2.switch_node_low[i])
          begin
            state_nxt.sl[i].st  = TGD_LS_DELAY;
            state_nxt.sl[i].tmr = '0;
          end
        end

        TGD_LS_DELAY:
        begin
          state_nxt.sl[i].tmr = tmr_step(state_r.sl[i].tmr);
          if (!run && !state_r.fault)
            state_nxt.sl[i].st = TGD_OFF;
          else if (state_r.sl[i].tmr == TMR_W'(DEAD_DELAY_CYC - 1))
          begin
            state_nxt.sl[i].st  = TGD_LS_ON;
            state_nxt.sl[i].tmr = '0;
          end
        end

        TGD_LS_ON:
        begin
          state_nxt.sl[i].tmr = tmr_step(state_r.sl[i].tmr);
          if (state_r.fault)
            state_nxt.sl[i].st = TGD_LS_ON;
          else if (!run)
            state_nxt.sl[i].st = TGD_OFF;
          else if (start && cmd && state_r.sl[i].tmr >= TMR_W'(MIN_LS_CYC - 1))
            state_nxt.sl[i].st = TGD_WAIT_LOW_SIDE_GATE_DRIVE;
        end

        default:
          state_nxt.sl[i].st = TGD_OFF;
      endcase

      // drive levels decoded from next state: one state, one switch on
      state_nxt.drv.high_side_gate_drive[i] = (state_nxt.sl[i].st == TGD_HS_ON);
      state_nxt.drv.low_side_gate_drive[i]  = (state_nxt.sl[i].st == TGD_LS_ON);
      state_nxt.drv.current_sense_window[i] = (state_nxt.sl[i].st == TGD_LS_ON);
    end

    state_nxt.pg = state_r.ctl2.enable && !state_nxt.fault;
  end

  // reset clears the synchronisers too, so inputs take two edges to be seen
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      state_r <= '0;
    else
      state_r <= state_nxt;
  end

  assign drive               = state_r.drv;
  assign power_good_allow    = state_r.pg;
  assign overvoltage_latched = state_r.fault;

endmodule : tgd_sequencer

// *** verilog/tgd_pkg.sv ***
package tgd_pkg;

  localparam int SLICES          = 2;
  localparam int CLK_PERIOD_NS   = 10;
  localparam int DEAD_DELAY_NS   = 50;
  localparam int DEAD_DELAY_CYC  = (DEAD_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MIN_LS_NS       = 330;
  localparam int MIN_LS_CYC      = (MIN_LS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MAX_DUTY_PCT    = 90;
  localparam int PCT_FULL        = 100;
  localparam int PERIOD_CYC_DEF  = 334;
  localparam int CNT_W           = 12;
  localparam int TMR_W           = 8;
  localparam int SLICE_A         = 0;

  typedef enum logic [2:0] {
    TGD_OFF,
    TGD_WAIT_LOW_SIDE_GATE_DRIVE,
    TGD_HS_ON,
    TGD_WAIT_SW,
    TGD_LS_DELAY,
    TGD_LS_ON
  } tgd_slice_e;

  typedef struct packed {
    logic [SLICES-1:0] pwm_cmd;
    logic [SLICES-1:0] switch_node_low;
    logic [SLICES-1:0] low_side_gate_low;
  } tgd_sense_s;

  typedef struct packed {
    logic overvoltage;
    logic enable;
    logic light_load_efficiency_mode;
  } tgd_ctl_s;

  typedef struct packed {
    logic [SLICES-1:0] high_side_gate_drive;
    logic [SLICES-1:0] low_side_gate_drive;
    logic [SLICES-1:0] current_sense_window;
  } tgd_drive_s;

  typedef struct packed {
    tgd_slice_e       st;
    logic [TMR_W-1:0] tmr;
  } tgd_slice_s;

endpackage : tgd_pkg

// *** tb/tgd_sequencer_properties.sv ***
`timescale 1ns/1ns
module tgd_sequencer_properties
  import tgd_pkg::*;
#(
  parameter int PERIOD_CYC = tgd_pkg::PERIOD_CYC_DEF
)
(
  input wire logic                ref_clk,
  input wire logic                rst,
  input wire tgd_pkg::tgd_sense_s sense,
  input wire tgd_pkg::tgd_ctl_s   ctl,
  input wire tgd_pkg::tgd_drive_s drive,
  input wire logic                power_good_allow,
  input wire logic                overvoltage_latched
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  wire [1:0] hs = drive.high_side_gate_drive;
  wire [1:0] ls = drive.low_side_gate_drive;
  // light mode held long enough for slice 0 to finish any pulse in flight
  logic [4:0] light_cnt;
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      light_cnt <= 5'h00;
    else if (!ctl.light_load_efficiency_mode)
      light_cnt <= 5'h00;
    else if (light_cnt != 5'h1f)
      light_cnt <= light_cnt + 5'h01;
  end
  chk_no_overlap: assert property ((hs & ls) == 2'b00)
    else $error("hs and ls on together");
  chk_isense_ls: assert property (drive.current_sense_window == ls)
    else $error("sense window off ls");
  chk_dead_time: assert property ($rose(ls[1]) |-> $past(hs[1], 6) == 1'b0)
    else $error("ls rose too soon");
  chk_gate_low: assert property ($rose(hs[1]) |-> $past(sense.low_side_gate_low[1], 3))
    else $error("hs rose before gate low");
  // enable loss may cut ls short, so it is excluded
  chk_ls_min: assert property ($fell(ls[1]) && ctl.enable && $past(ctl.enable, 6) |-> $past(ls[1], 30))
    else $error("ls pulse short");
  chk_light_off: assert property (light_cnt == 5'h1f && !overvoltage_latched |-> !hs[0] && !ls[0])
    else $error("slice 0 switched");
  chk_fault_hs: assert property (overvoltage_latched |=> hs == 2'b00 && overvoltage_latched)
    else $error("fault not held");
  chk_pg_enable: assert property (!ctl.enable [*4] |-> !power_good_allow)
    else $error("power good with enable low");
  chk_reset_off: assert property ($fell(rst) |-> drive == '0 && !power_good_allow)
    else $error("drive after reset");
  cover property ($rose(hs[0]));
  cover property ($rose(overvoltage_latched));
  cover property ($fell(power_good_allow));
endmodule : tgd_sequencer_properties

bind tgd_sequencer tgd_sequencer_properties #(.PERIOD_CYC(PERIOD_CYC)) i_props (.ref_clk(ref_clk),
  .rst(rst), .sense(sense), .ctl(ctl), .drive(drive), .power_good_allow(power_good_allow),
  .overvoltage_latched(overvoltage_latched));

// *** tb/tgd_fet_model.sv ***
`timescale 1ns/1ns
module tgd_fet_model
  import tgd_pkg::*;
(
  input  wire logic                ref_clk,
  input  wire logic                slow,
  input  wire tgd_pkg::tgd_drive_s drive,
  output      logic [1:0]          switch_node_low,
  output      logic [1:0]          low_side_gate_low
);
  // slow stretches every gate and node edge to four clocks
  logic [3:0][1:0] hs_q = '0;
  logic [3:0][1:0] ls_q = '0;
  always_ff @(posedge ref_clk)
  begin
    hs_q <= {hs_q[2:0], drive.high_side_gate_drive};
    ls_q <= {ls_q[2:0], drive.low_side_gate_drive};
  end
  assign switch_node_low   = ~(slow ? hs_q[3] : hs_q[0]);
  assign low_side_gate_low = ~(slow ? ls_q[3] : ls_q[0]);
endmodule : tgd_fet_model

// *** tb/test_tgd_sequencer.sv ***
`timescale 1ns/1ns
module test_tgd_sequencer;
  import tgd_pkg::*;
  localparam int P = 100;
  logic       ref_clk = 1'b0;
  logic       rst     = 1'b1;
  logic       slow    = 1'b0;
  logic [1:0] pwm     = 2'b00;
  logic [1:0] snl;
  logic [1:0] gll;
  logic [1:0] hs_q    = 2'b00;
  tgd_ctl_s   ctl     = '{1'b0, 1'b1, 1'b0};
  tgd_drive_s drive;
  logic       pg;
  logic       ovl;
  int         err_total = 0;
  int         samples_checked = 0;
  int         seed = 42051;
  int         tl, cyc, win, w, wmax;
  int         rises [2];
  int         t_rise [2];
  tgd_sequencer #(.PERIOD_CYC(P)) i_tgd_sequencer (.ref_clk(ref_clk), .rst(rst),
    .sense(tgd_sense_s'{pwm, snl, gll}), .ctl(ctl), .drive(drive), .power_good_allow(pg),
    .overvoltage_latched(ovl));
  tgd_fet_model i_tgd_fet_model (.ref_clk(ref_clk), .slow(slow), .drive(drive),
    .switch_node_low(snl), .low_side_gate_low(gll));
  initial
  begin
    forever #5 ref_clk = ~ref_clk;
  end
  // command window straddles local time zero, so a slip of a cycle is harmless
  always @(posedge ref_clk)
  begin
    #1;
    tl = rst ? 0 : tl + 1;
    for (int i = 0; i < 2; i++)
      pwm[i] = win ? ((tl + 10 + i * P / 2) % P < win) : 1'($random(seed));
  end
  // sampled mid-cycle so the drive outputs have settled
  always @(negedge ref_clk)
  begin
    cyc++;
    hs_q <= drive.high_side_gate_drive;
    for (int i = 0; i < 2; i++)
      if (drive.high_side_gate_drive[i] && !hs_q[i])
      begin
        rises[i]++;
        t_rise[i] = cyc;
      end
    w = drive.high_side_gate_drive[1] ? w + 1 : 0;
    wmax = (w > wmax) ? w : wmax;
  end
  function automatic int hs_lim(input int p);
    int a;
    a = p * MAX_DUTY_PCT / PCT_FULL;
    return (a < p - MIN_LS_CYC - DEAD_DELAY_CYC) ? a : p - MIN_LS_CYC - DEAD_DELAY_CYC;
  endfunction : hs_lim
  task automatic cycles(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cycles
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic do_reset;
    rst = 1'b1;
    cycles(10);
    rst = 1'b0;
  endtask : do_reset
  task automatic results;
    $display("compares %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results
  initial
  begin
    do_reset();
    cycles(2000);
    $display("test random done");
    for (int s = 0; s < 2; s++)
    begin
      slow = s[0];
      win = 40;
      cycles(2 * P);
      rises = '{0, 0};
      wmax = 0;
      cycles(4 * P);
      check(rises[0], 4);
      check(rises[1], 4);
      check((t_rise[1] - t_rise[0] + P) % P, P / 2);
      check(wmax > 20 && wmax < 30, 1);
      win = 90;
      cycles(2 * P);
      wmax = 0;
      cycles(4 * P);
      check(wmax < hs_lim(P) && wmax > hs_lim(P) - 10, 1);
      $display("test interleave done");
    end
    win = 40;
    ctl.enable = 1'b0;
    cycles(20);
    check(pg, 0);
    check({drive.high_side_gate_drive, drive.low_side_gate_drive}, 0);
    ctl.enable = 1'b1;
    cycles(20);
    check(pg, 1);
    $display("test enable done");
    ctl.light_load_efficiency_mode = 1'b1;
    do_reset();
    rises = '{0, 0};
    cycles(3 * P);
    check(rises[0], 0);
    check(rises[1], 3);
    ctl.light_load_efficiency_mode = 1'b0;
    $display("test light done");
    ctl.overvoltage = 1'b1;
    cycles(40);
    check(ovl, 1);
    ctl.overvoltage = 1'b0;
    cycles(2 * P);
    check(ovl, 1);
    check(drive.high_side_gate_drive, 0);
    check(drive.low_side_gate_drive, 2'b11);
    check(drive.current_sense_window, 2'b11);
    do_reset();
    check(drive, 0);
    check(ovl, 0);
    $display("test fault done");
    results();
  end
  initial
  begin
    #100000;
    err_total++;
    results();
  end
endmodule : test_tgd_sequencer
